/* File: hw/rft_timing.sv */
// Chosen here: the plain strobed port.
`timescale 1ns/100ps
// Notes on behaviour
// - a write to code B0h loads one 8-bit byte of path, mode and four polarities.
// - the port setting acts from the cycle after the write, frames are not awaited.
// - path bit 0 sends pixels straight to the shift register, 1 through memory.
// - vsync and hsync level bits make their input active low at 0, high at 1.
// - the pixel clock bit samples on the rising edge at 0, the falling edge at 1.
// - the data enable bit makes enable active high at 0, active low at 1.
// - port mode 00 and 01 pick the system interface, 10 DE mode, 11 sync mode.
// - code B1h holds two bytes of frame timing used only in normal mode.
// - byte one has extra clocks in 7:2 and divider in 1:0, byte two extra lines in 4:0.
// - divider codes 0 to 3 stretch one operation clock over 1 to 4 oscillator cycles.
// - all display timing steps on the divided clock enable.
// - a frame is div x (240+row pitch+extra clocks) x (320+interval+extra lines).
// - the row pitch term is a fixed clock count that lets the source latch a line.
// - code B2h has the same layout and is used only in partial mode.
// - code B3h has the same layout and is used only in idle mode.
// - inversion code 00 column, 01 one dot, 10 two dot, 11 reserved.
module rft_timing
  import rft_pkg::*;
#(
  parameter int SRC_H = RFT_SRC_H,
  parameter int SRC_V = RFT_SRC_V
)
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire logic i_vsync,
  input wire logic i_hsync,
  input wire logic i_pclk,
  input wire logic i_de,
  input wire logic [17:0] i_pixel,
  output logic o_vsync_act,
  output logic o_hsync_act,
  output logic o_de_act,
  output logic o_pixel_stb,
  output logic [17:0] o_pixel,
  output logic o_pixel_to_mem,
  output logic o_pixel_to_shift,
  output logic [1:0] o_port_mode,
  output logic o_rgb_active,
  output logic [1:0] o_inv_mode,
  output logic o_op_tick,
  output logic o_line_start,
  output logic o_frame_start,
  output logic [8:0] o_line_num
);

  // register file, one flop group per command code
  logic [7:0] rgb_ctrl_q;
  logic [15:0] fr_normal_q;
  logic [15:0] fr_partial_q;
  logic [15:0] fr_idle_q;
  logic [1:0] inv_q;
  logic [1:0] mode_q;
  logic [15:0] rdata_q;
  logic [15:0] rdata_mux;

  // timing counters and their next values
  logic [1:0] div_cnt_q;
  logic [1:0] div_cnt_d;
  logic [8:0] clk_cnt_q;
  logic [8:0] clk_cnt_d;
  logic [8:0] line_cnt_q;
  logic [8:0] line_cnt_d;
  logic frame_start_q;
  logic line_start_q;

  // pixel port capture
  logic pclk_q;
  logic pix_stb_q;
  logic [17:0] pix_q;
  logic vs_q;
  logic hs_q;
  logic de_q;

  function automatic logic wr_hit(input logic [7:0] addr, input logic [7:0] code);
    wr_hit = (addr == code);
  endfunction

  function automatic logic [1:0] fr_div(input logic [15:0] fr);
    fr_div = fr[RFT_FR_DIV_HI:RFT_FR_DIV_LO];
  endfunction

  function automatic logic [5:0] fr_extra_clk(input logic [15:0] fr);
    fr_extra_clk = fr[RFT_FR_H_HI:RFT_FR_H_LO];
  endfunction

  function automatic logic [4:0] fr_extra_line(input logic [15:0] fr);
    fr_extra_line = fr[RFT_FR_V_HI:RFT_FR_V_LO];
  endfunction

  // write decode, one strobe per command code
  wire wr_rgb = i_wr && wr_hit(i_addr, RFT_ADDR_RGB_CTRL);
  wire wr_fr_normal = i_wr && wr_hit(i_addr, RFT_ADDR_FR_NORMAL);
  wire wr_fr_partial = i_wr && wr_hit(i_addr, RFT_ADDR_FR_PARTIAL);
  wire wr_fr_idle = i_wr && wr_hit(i_addr, RFT_ADDR_FR_IDLE);
  wire wr_inv = i_wr && wr_hit(i_addr, RFT_ADDR_INV_CTRL);
  wire wr_mode = i_wr && wr_hit(i_addr, RFT_ADDR_MODE);

  // the mode register picks which of the three timing sets runs
  wire sel_partial = mode_q[RFT_MODE_PARTIAL];
  wire sel_idle = mode_q[RFT_MODE_IDLE];
  // idle wins over partial, both set means reduced colour on a partial area
  wire [15:0] fr_sel = sel_idle ? fr_idle_q : (sel_partial ? fr_partial_q : fr_normal_q);
  wire [1:0] div_code = fr_div(fr_sel);
  wire [5:0] extra_clk = fr_extra_clk(fr_sel);
  wire [4:0] extra_line = fr_extra_line(fr_sel);

  // row pitch is fixed so the source always finishes latching
  wire [8:0] line_len = 9'(RFT_ACTIVE_CLOCKS + SRC_H) + 9'(extra_clk);
  wire [8:0] frame_len = 9'(RFT_ACTIVE_LINES + SRC_V) + 9'(extra_line);
  wire tick = (div_cnt_q == div_code);
  wire line_end = tick && (clk_cnt_q == line_len - 9'd1);
  wire frame_end = line_end && (line_cnt_q == frame_len - 9'd1);

  // a shorter line set mid-line lets the counter wrap once, one odd line only
  assign div_cnt_d = tick ? 2'b00 : div_cnt_q + 2'b01;
  assign clk_cnt_d = !tick ? clk_cnt_q : (line_end ? 9'h000 : clk_cnt_q + 9'h001);
  assign line_cnt_d = frame_end ? 9'h000 : (line_end ? line_cnt_q + 9'h001 : line_cnt_q);

  wire [1:0] rcm = rgb_ctrl_q[RFT_BIT_RCM_HI:RFT_BIT_RCM_LO];
  wire rgb_on = (rcm == RFT_PORT_DE) || (rcm == RFT_PORT_SYNC);
  // the pin xnor its polarity bit gives the vsync and hsync active level, the pin xor the bit gives enable
  wire vs_act = i_vsync ~^ rgb_ctrl_q[RFT_BIT_VSPL];
  wire hs_act = i_hsync ~^ rgb_ctrl_q[RFT_BIT_HSPL];
  wire de_act = i_de ^ rgb_ctrl_q[RFT_BIT_EPL];
  // pclk is sampled on the system clock, so it must run well below it
  wire pclk_rise = i_pclk && !pclk_q;
  wire pclk_fall = !i_pclk && pclk_q;
  wire pclk_edge = rgb_ctrl_q[RFT_BIT_DPL] ? pclk_fall : pclk_rise;
  wire pix_take = rgb_on && pclk_edge && (rcm == RFT_PORT_SYNC || de_act);

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rgb_ctrl_q <= RFT_RST_RGB_CTRL;
    end
    else if (wr_rgb)
    begin
      rgb_ctrl_q <= i_wdata[7:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      fr_normal_q <= RFT_RST_FR;
    end
    else if (wr_fr_normal)
    begin
      fr_normal_q <= i_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      fr_partial_q <= RFT_RST_FR;
    end
    else if (wr_fr_partial)
    begin
      fr_partial_q <= i_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      fr_idle_q <= RFT_RST_FR;
    end
    else if (wr_fr_idle)
    begin
      fr_idle_q <= i_wdata;
    end
  end

  // reserved code 11 is stored as written, the panel side must ignore it
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      inv_q <= RFT_RST_INV_CTRL[1:0];
    end
    else if (wr_inv)
    begin
      inv_q <= i_wdata[1:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      mode_q <= RFT_RST_MODE[1:0];
    end
    else if (wr_mode)
    begin
      mode_q <= i_wdata[1:0];
    end
  end

  always_comb
  begin
    case (i_addr)
      RFT_ADDR_RGB_CTRL: rdata_mux = {8'h00, rgb_ctrl_q};
      RFT_ADDR_FR_NORMAL: rdata_mux = fr_normal_q;
      RFT_ADDR_FR_PARTIAL: rdata_mux = fr_partial_q;
      RFT_ADDR_FR_IDLE: rdata_mux = fr_idle_q;
      RFT_ADDR_INV_CTRL: rdata_mux = {14'h0000, inv_q};
      RFT_ADDR_MODE: rdata_mux = {14'h0000, mode_q};
      RFT_ADDR_STATUS: rdata_mux = {7'h00, line_cnt_q};
      default: rdata_mux = 16'h0000;
    endcase
  end

  // read data stands for one cycle only, zero otherwise
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rdata_q <= 16'h0000;
    end
    else if (i_rd)
    begin
      rdata_q <= rdata_mux;
    end
    else
    begin
      rdata_q <= 16'h0000;
    end
  end

  // the divider counts every cycle, the clock and line counters only advance on the divided enable
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      div_cnt_q <= 2'b00;
    end
    else
    begin
      div_cnt_q <= div_cnt_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      clk_cnt_q <= 9'h000;
    end
    else
    begin
      clk_cnt_q <= clk_cnt_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      line_cnt_q <= 9'h000;
    end
    else
    begin
      line_cnt_q <= line_cnt_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      line_start_q <= 1'b0;
      frame_start_q <= 1'b0;
    end
    else
    begin
      line_start_q <= line_end;
      frame_start_q <= frame_end;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pclk_q <= 1'b0;
    end
    else
    begin
      pclk_q <= i_pclk;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pix_stb_q <= 1'b0;
    end
    else
    begin
      pix_stb_q <= pix_take;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pix_q <= 18'h0_0000;
    end
    else if (pix_take)
    begin
      pix_q <= i_pixel;
    end
  end

  // sync levels read zero while the system interface is selected
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      vs_q <= 1'b0;
      hs_q <= 1'b0;
      de_q <= 1'b0;
    end
    else
    begin
      vs_q <= rgb_on && vs_act;
      hs_q <= rgb_on && hs_act;
      de_q <= rgb_on && de_act;
    end
  end

  assign o_rdata = rdata_q;
  assign o_pixel_stb = pix_stb_q;
  assign o_pixel = pix_q;
  assign o_pixel_to_mem = pix_stb_q && rgb_ctrl_q[RFT_BIT_BYPASS];
  assign o_pixel_to_shift = pix_stb_q && !rgb_ctrl_q[RFT_BIT_BYPASS];
  assign o_vsync_act = vs_q;
  assign o_hsync_act = hs_q;
  assign o_de_act = de_q;
  assign o_port_mode = rcm;
  assign o_rgb_active = rgb_on;
  assign o_inv_mode = inv_q;
  assign o_op_tick = tick;
  assign o_line_start = line_start_q;
  assign o_frame_start = frame_start_q;
  assign o_line_num = line_cnt_q;
endmodule

/* File: hw/rft_pkg.sv */
package rft_pkg;
  localparam logic [7:0] RFT_ADDR_RGB_CTRL = 8'hB0;
  localparam logic [7:0] RFT_ADDR_FR_NORMAL = 8'hB1;
  localparam logic [7:0] RFT_ADDR_FR_PARTIAL = 8'hB2;
  localparam logic [7:0] RFT_ADDR_FR_IDLE = 8'hB3;
  localparam logic [7:0] RFT_ADDR_INV_CTRL = 8'hB4;
  localparam logic [7:0] RFT_ADDR_STATUS = 8'hB8;
  localparam logic [7:0] RFT_ADDR_MODE = 8'hB9;

  localparam logic [7:0] RFT_RST_RGB_CTRL = 8'h40;
  localparam logic [15:0] RFT_RST_FR = 16'h920B;
  localparam logic [7:0] RFT_RST_INV_CTRL = 8'h01;
  localparam logic [7:0] RFT_RST_MODE = 8'h00;

  localparam int RFT_BIT_BYPASS = 7;
  localparam int RFT_BIT_RCM_HI = 6;
  localparam int RFT_BIT_RCM_LO = 5;
  localparam int RFT_BIT_VSPL = 3;
  localparam int RFT_BIT_HSPL = 2;
  localparam int RFT_BIT_DPL = 1;
  localparam int RFT_BIT_EPL = 0;
  localparam int RFT_FR_H_HI = 15;
  localparam int RFT_FR_H_LO = 10;
  localparam int RFT_FR_DIV_HI = 9;
  localparam int RFT_FR_DIV_LO = 8;
  localparam int RFT_FR_V_HI = 4;
  localparam int RFT_FR_V_LO = 0;
  localparam int RFT_MODE_PARTIAL = 0;
  localparam int RFT_MODE_IDLE = 1;

  localparam int RFT_ACTIVE_CLOCKS = 240;
  localparam int RFT_ACTIVE_LINES = 320;
  localparam int RFT_SRC_H = 16;
  localparam int RFT_SRC_V = 4;

  typedef enum logic [1:0] {
    RFT_PORT_SYS0,
    RFT_PORT_SYS1,
    RFT_PORT_DE,
    RFT_PORT_SYNC
  } rft_port_mode_t;

  typedef enum logic [1:0] {
    RFT_INV_COLUMN,
    RFT_INV_DOT1,
    RFT_INV_DOT2,
    RFT_INV_RSVD
  } rft_inv_t;
endpackage

/* File: testbench/rft_host_model.sv */
`timescale 1ns/100ps
module rft_host_model (
  input wire logic i_clk,
  input wire logic i_dpl,
  output logic o_pclk,
  output logic [17:0] o_pix
);
  int n;
  // data moves on the edge opposite to sampling, so setup is half a period
  initial
  begin
    n = 0;
    o_pclk = 1'b0;
    o_pix = 18'h0_0000;
    forever
    begin
      @(posedge i_clk);
      n <= n + 1;
      if (n % 8 == 7)
      begin
        o_pclk <= ~o_pclk;
        if (o_pclk ^ i_dpl)
          o_pix <= o_pix + 18'h0_0101;
      end
    end
  end
endmodule

/* File: testbench/rft_timing_checker.sv */
`timescale 1ns/100ps
module rft_timing_checker
  import rft_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic [1:0] o_port_mode,
  input wire logic [1:0] o_inv_mode,
  input wire logic o_rgb_active,
  input wire logic o_pixel_to_mem,
  input wire logic o_pixel_to_shift,
  input wire logic o_line_start
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire wr_port = i_wr && i_addr == RFT_ADDR_RGB_CTRL;
  wire wr_inv = i_wr && i_addr == RFT_ADDR_INV_CTRL;
  property p_port_load;
    wr_port |=> o_port_mode == $past(i_wdata[6:5]);
  endproperty
  a_port_load: assert property (p_port_load) else $error("port mode load");
  property p_port_hold;
    !wr_port |=> $stable(o_port_mode);
  endproperty
  a_port_hold: assert property (p_port_hold) else $error("port mode drift");
  property p_inv_load;
    wr_inv |=> o_inv_mode == $past(i_wdata[1:0]);
  endproperty
  a_inv_load: assert property (p_inv_load) else $error("inversion load");
  property p_inv_hold;
    !wr_inv |=> $stable(o_inv_mode);
  endproperty
  a_inv_hold: assert property (p_inv_hold) else $error("inversion drift");
  property p_rgb;
    o_rgb_active == o_port_mode[1];
  endproperty
  a_rgb: assert property (p_rgb) else $error("rgb mode flag");
  property p_path;
    !(o_pixel_to_mem && o_pixel_to_shift);
  endproperty
  a_path: assert property (p_path) else $error("both pixel paths");
  property p_rdback;
    i_rd && i_addr == RFT_ADDR_RGB_CTRL |=> o_rdata[6:5] == $past(o_port_mode);
  endproperty
  a_rdback: assert property (p_rdback) else $error("port read back");
  property p_line;
    o_line_start |=> !o_line_start [*8];
  endproperty
  a_line: assert property (p_line) else $error("line pulse spacing");
  c_port: cover property (wr_port);
  c_inv: cover property (wr_inv);
  c_line: cover property (o_line_start);
endmodule
bind rft_timing rft_timing_checker u_chk (.*);

/* File: testbench/rgb_port_and_frame_timing_config_tb.sv */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module rgb_port_and_frame_timing_config_tb
  import rft_pkg::*;
;
  logic i_clk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic i_vsync = 1'b0, i_hsync = 1'b0, i_de = 1'b0, dpl = 1'b0, pclk;
  logic [7:0] i_addr = 8'h00, d;
  logic [15:0] i_wdata = 16'h0000, o_rdata;
  logic [17:0] pix, o_pixel;
  logic [1:0] o_port_mode, o_inv_mode;
  logic o_vsync_act, o_hsync_act, o_de_act, o_pixel_stb, o_pixel_to_mem, o_line_start;
  logic o_pixel_to_shift, o_rgb_active;
  logic [31:0] seed = 32'h0000_0002, on;
  logic [15:0] fr [3];
  int n_fail = 0, compares = 0, c;
  rft_host_model u_host (.i_clk(i_clk), .i_dpl(dpl), .o_pclk(pclk), .o_pix(pix));
  rft_timing DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_vsync(i_vsync), .i_hsync(i_hsync),
    .i_pclk(pclk), .i_de(i_de), .i_pixel(pix), .o_vsync_act(o_vsync_act),
    .o_hsync_act(o_hsync_act), .o_de_act(o_de_act), .o_pixel_stb(o_pixel_stb),
    .o_pixel(o_pixel), .o_pixel_to_mem(o_pixel_to_mem), .o_pixel_to_shift(o_pixel_to_shift),
    .o_port_mode(o_port_mode), .o_rgb_active(o_rgb_active), .o_inv_mode(o_inv_mode),
    .o_op_tick(),
    .o_line_start(o_line_start), .o_frame_start(), .o_line_num());
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int gap(logic [15:0] v);
    return (int'(v[9:8]) + 1) * (RFT_ACTIVE_CLOCKS + RFT_SRC_H + int'(v[15:10]));
  endfunction
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    `CHK("rdata", e, o_rdata)
  endtask
  // bounded wait, a stuck signal shows up as a wrong count
  task automatic wait_hi(input int which, input int lim);
    c = 0;
    do
    begin
      @(posedge i_clk);
      #1;
      c++;
    end while ((which ? o_pixel_stb : o_line_start) !== 1'b1 && c < lim);
  endtask
  task automatic summarize();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    forever #5 i_clk = ~i_clk;
  end
  initial
  begin
    repeat (60000) @(posedge i_clk);
    n_fail++;
    summarize();
  end
  initial
  begin
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(RFT_ADDR_RGB_CTRL, 16'h0040);
    rd(RFT_ADDR_FR_NORMAL, 16'h920B);
    rd(RFT_ADDR_FR_PARTIAL, 16'h920B);
    rd(RFT_ADDR_FR_IDLE, 16'h920B);
    rd(RFT_ADDR_INV_CTRL, 16'h0001);
    rd(8'hC0, 16'h0000);
    $display("reset values done");
    for (int g = 0; g < 4; g++)
    begin
      // bit 4 kept clear, it is a don't-care
      d = (rnd() & 8'h8F) | (g << 5);
      on = rnd();
      wr(RFT_ADDR_RGB_CTRL, {8'h00, d});
      `CHK("port_mode", g[1:0], o_port_mode)
      `CHK("rgb_active", g[1], o_rgb_active)
      wr(RFT_ADDR_INV_CTRL, {14'h0000, on[5:4] & {1'b1, ~on[5]}});
      `CHK("inv_mode", on[5:4] & {1'b1, ~on[5]}, o_inv_mode)
      i_vsync <= on[0] ~^ d[3];
      i_hsync <= on[1] ~^ d[2];
      i_de <= on[2] ^ d[0];
      repeat (4) @(posedge i_clk);
      #1;
      `CHK("vsync", on[0] & g[1], o_vsync_act)
      `CHK("hsync", on[1] & g[1], o_hsync_act)
      `CHK("de", on[2] & g[1], o_de_act)
    end
    $display("port and polarity done");
    for (int g = 0; g < 4; g++)
    begin
      dpl <= g[0];
      i_de <= 1'b1;
      wr(RFT_ADDR_RGB_CTRL, {8'h00, 8'(8'h40 | (g[1] << 7) | (g[0] << 1))});
      wait_hi(1, 100);
      wait_hi(1, 100);
      `CHK("pixel", pix, o_pixel)
      `CHK("to_mem", g[1], o_pixel_to_mem)
      `CHK("to_shift", !g[1], o_pixel_to_shift)
    end
    $display("pixel path done");
    for (int g = 0; g < 3; g++)
    begin
      fr[g] = rnd() & 16'hFF1F;
      wr(RFT_ADDR_FR_NORMAL + g, fr[g]);
      rd(RFT_ADDR_FR_NORMAL + g, fr[g]);
    end
    for (int g = 0; g < 3; g++)
    begin
      wr(RFT_ADDR_MODE, g);
      repeat (3) wait_hi(0, 3000);
      `CHK("line_gap", gap(fr[g]), c)
    end
    $display("frame timing done");
    summarize();
  end
endmodule
